// ---- hw/lane_map_pkg.sv ----
package lane_map_pkg;

  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int CS_COUNT   = 8;
  localparam int SEL_W      = 3;
  localparam int ADDR_W     = 26;
  localparam int SYS_ADDR_W = ADDR_W + SEL_W;
  localparam int DATA_W     = 32;
  localparam int LANES      = 4;
  localparam int PAGE_LSB   = 5;
  localparam int TIM_W      = 4;

  // ------------------------------------------------------------
  // Field encodings
  // ------------------------------------------------------------
  localparam logic [1:0] WIDTH_8   = 2'h0;
  localparam logic [1:0] WIDTH_16  = 2'h1;
  localparam logic [1:0] WIDTH_32  = 2'h2;
  localparam logic       BAT_SEL   = 1'h0;
  localparam logic       BAT_WRITE = 1'h1;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;

  // ------------------------------------------------------------
  // Slow clock waveform, in master clock cycles
  // ------------------------------------------------------------
  localparam logic [TIM_W-1:0] SLOW_SETUP = 4'h1;
  localparam logic [TIM_W-1:0] SLOW_PULSE = 4'h3;
  localparam logic [TIM_W-1:0] SLOW_HOLD  = 4'h1;
  localparam logic [TIM_W-1:0] TIM_ONE    = 4'h1;
  localparam logic [TIM_W-1:0] TIM_ZERO   = 4'h0;

  localparam logic [LANES-1:0] LANES_NONE = 4'h0;
  localparam logic [LANES-1:0] LANES_ALL  = 4'hF;
  localparam logic [LANES-1:0] LANE_LO2   = 4'h3;
  localparam logic [LANES-1:0] LANE_ONE   = 4'h1;
  localparam logic [CS_COUNT-1:0] CS_IDLE = 8'hFF;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_SETUP = 2'h1,
    ST_PULSE = 2'h3,
    ST_HOLD  = 2'h2
  } acc_state_t;

endpackage

// ---- hw/static_memory_lane_mapping.sv ----
`timescale 1ns/10ps
// Functional notes
// - Eight low chip selects, 26-bit address bus
// - Per-select width of 8, 16, 32
// - Each select spans 64 Mbytes, wraps
// - Significant address bits follow width
// - Low wait input stretches current access
// - Slow clock mode uses fixed slow waveforms
// - Page-mode burst reads, 32-byte pages
// - Access type field picks strobes or selects
// - 16-bit strobes: lane0 low, lane1 high
// - 32-bit strobes: lanes 0 to 3
// - Boot forces byte select access type on select 0
// - Byte select: lane selects, one write enable
// - Byte select lanes follow width
// - Low address bits unused on wide devices
// - Unused strobes or selects stay inactive
// - Shared pins translated by width, type
// - Address bit 1 pin shared with lane 2
// - All strobes, selects, wait active low
// - Timing per select in master cycles
module static_memory_lane_mapping
  import lane_map_pkg::*;
(
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_rst,
  input  wire logic                      i_clk_en,
  input  wire logic                      i_req_valid,
  input  wire logic                      i_req_write,
  input  wire logic [SYS_ADDR_W-1:0]     i_req_addr,
  input  wire logic [1:0]                i_req_size,
  input  wire logic [DATA_W-1:0]         i_req_wdata,
  input  wire logic [2*CS_COUNT-1:0]     i_bus_width_field,
  input  wire logic [CS_COUNT-1:0]       i_byte_access_type_field,
  input  wire logic [CS_COUNT-1:0]       i_page_mode_en,
  input  wire logic [TIM_W*CS_COUNT-1:0] i_setup_cycles,
  input  wire logic [TIM_W*CS_COUNT-1:0] i_pulse_cycles,
  input  wire logic [TIM_W*CS_COUNT-1:0] i_hold_cycles,
  input  wire logic                      i_slow_clock_mode,
  input  wire logic                      i_boot_mode,
  input  wire logic                      i_ext_wait_request_n,
  input  wire logic [DATA_W-1:0]         i_data_in,
  output logic                           o_req_ready,
  output logic                           o_done,
  output logic [DATA_W-1:0]              o_rdata,
  output logic [CS_COUNT-1:0]            o_chip_select_n_lines,
  output logic [ADDR_W-1:2]              o_addr_hi,
  output logic                           o_read_strobe_n,
  output logic                           o_pin0_a0_lane0_select_n,
  output logic                           o_pin1_write_enable_n,
  output logic                           o_pin2_lane1_n,
  output logic                           o_pin_a1_lane2_n,
  output logic                           o_pin3_lane3_n,
  output logic [DATA_W-1:0]              o_data_out,
  output logic                           o_data_oe_n
);

  // ------------------------------------------------------------
  // Access sequencer state
  // ------------------------------------------------------------
  // Pin inputs pass two flops; only the second one is read
  logic              wait_meta_q;
  logic              wait_sync_q;
  logic [DATA_W-1:0] din_meta_q;
  logic [DATA_W-1:0] din_sync_q;
  acc_state_t             state_q, state_d;
  logic [TIM_W-1:0]       cnt_q, cnt_d;
  logic [SEL_W-1:0]       cs_q, cs_d;
  logic [ADDR_W-1:0]      addr_q, addr_d;
  logic                   wr_q, wr_d;
  logic [LANES-1:0]       be_q, be_d;
  logic [1:0]             width_q, width_d;
  logic                   bat_q, bat_d;
  logic                   page_vld_q, page_vld_d;
  logic [SYS_ADDR_W-1:PAGE_LSB] page_q, page_d;
  logic [TIM_W-1:0]       pulse_q, pulse_d;
  logic [TIM_W-1:0]       hold_q, hold_d;
  logic                   ready_q, ready_d;
  logic                   done_q, done_d;
  logic [DATA_W-1:0]      rdata_q, rdata_d;
  logic [DATA_W-1:0]      wdata_q, wdata_d;
  // Selected select's configuration at request time
  logic [SEL_W-1:0]       req_cs;
  logic [1:0]             req_width;
  logic                   req_bat;
  logic [TIM_W-1:0]       req_setup;
  logic [TIM_W-1:0]       req_pulse;
  logic [TIM_W-1:0]       req_hold;
  logic [LANES-1:0]       req_be;
  logic                   page_hit;

  always_comb begin
    req_cs    = i_req_addr[SYS_ADDR_W-1:ADDR_W];
    req_width = i_bus_width_field[2*req_cs +: 2];
    req_bat   = (i_boot_mode && (req_cs == '0)) ? BAT_SEL
              : i_byte_access_type_field[req_cs];
    req_setup = i_slow_clock_mode ? SLOW_SETUP
              : i_setup_cycles[TIM_W*req_cs +: TIM_W];
    req_pulse = i_slow_clock_mode ? SLOW_PULSE
              : i_pulse_cycles[TIM_W*req_cs +: TIM_W];
    req_hold  = i_slow_clock_mode ? SLOW_HOLD
              : i_hold_cycles[TIM_W*req_cs +: TIM_W];
    // A null pulse is not legal; it is widened to one cycle
    if (req_pulse == TIM_ZERO) begin
      req_pulse = TIM_ONE;
    end
    // Lanes touched by this access, per device width
    case (req_width)
      WIDTH_32: begin
        req_be = (i_req_size == SIZE_BYTE) ? (LANE_ONE << i_req_addr[1:0])
               : (i_req_size == SIZE_HALF)
               ? (LANE_LO2 << {i_req_addr[1], 1'b0}) : LANES_ALL;
      end
      WIDTH_16: begin
        req_be = (i_req_size == SIZE_BYTE) ? (LANE_ONE << i_req_addr[0])
               : LANE_LO2;
      end
      default: begin
        req_be = LANE_ONE;
      end
    endcase
    page_hit = page_vld_q && !i_req_write && i_page_mode_en[req_cs]
               && (page_q == i_req_addr[SYS_ADDR_W-1:PAGE_LSB]);
  end
  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    cs_d       = cs_q;
    addr_d     = addr_q;
    wr_d       = wr_q;
    be_d       = be_q;
    width_d    = width_q;
    bat_d      = bat_q;
    page_vld_d = page_vld_q;
    page_d     = page_q;
    pulse_d    = pulse_q;
    hold_d     = hold_q;
    ready_d    = ready_q;
    done_d     = 1'b0;
    rdata_d    = rdata_q;
    wdata_d    = wdata_q;
    case (state_q)
      ST_IDLE: begin
        if (i_req_valid && ready_q) begin
          ready_d    = 1'b0;
          cs_d       = req_cs;
          addr_d     = i_req_addr[ADDR_W-1:0];
          wr_d       = i_req_write;
          be_d       = req_be;
          width_d    = req_width;
          bat_d      = req_bat;
          pulse_d    = req_pulse;
          hold_d     = req_hold;
          wdata_d    = i_req_wdata;
          page_d     = i_req_addr[SYS_ADDR_W-1:PAGE_LSB];
          page_vld_d = !i_req_write && i_page_mode_en[req_cs];
          // Same-page reads skip the address setup phase
          if (page_hit || (req_setup == TIM_ZERO)) begin
            state_d = ST_PULSE;
            cnt_d   = req_pulse - TIM_ONE;
          end else begin
            state_d = ST_SETUP;
            cnt_d   = req_setup - TIM_ONE;
          end
        end
      end
      ST_SETUP: begin
        if (cnt_q == TIM_ZERO) begin
          state_d = ST_PULSE;
          cnt_d   = pulse_q - TIM_ONE;
        end else begin
          cnt_d = cnt_q - TIM_ONE;
        end
      end
      ST_PULSE: begin
        if (!wait_sync_q) begin
          cnt_d = cnt_q;
        end else if (cnt_q == TIM_ZERO) begin
          rdata_d = wr_q ? rdata_q : din_sync_q;
          if (hold_q == TIM_ZERO) begin
            state_d = ST_IDLE;
            ready_d = 1'b1;
            done_d  = 1'b1;
          end else begin
            state_d = ST_HOLD;
            cnt_d   = hold_q - TIM_ONE;
          end
        end else begin
          cnt_d = cnt_q - TIM_ONE;
        end
      end
      ST_HOLD: begin
        if (cnt_q == TIM_ZERO) begin
          state_d = ST_IDLE;
          ready_d = 1'b1;
          done_d  = 1'b1;
        end else begin
          cnt_d = cnt_q - TIM_ONE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        ready_d = 1'b1;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Pin translation
  // ------------------------------------------------------------
  logic [CS_COUNT-1:0] cs_n_d;
  logic                rd_n_d;
  logic                pin0_d;
  logic                pin1_d;
  logic                pin2_d;
  logic                pin_a1_d;
  logic                pin3_d;
  logic                oe_n_d;
  logic                active_d;
  logic                strobe_d;

  always_comb begin
    active_d = (state_d != ST_IDLE);
    strobe_d = (state_d == ST_PULSE);
    cs_n_d   = CS_IDLE;
    cs_n_d[cs_d] = !(active_d && (state_d != ST_HOLD));
    rd_n_d = !(strobe_d && !wr_d);
    oe_n_d = !(wr_d && (state_d == ST_PULSE || state_d == ST_HOLD));
    pin0_d   = 1'b1;
    pin1_d   = 1'b1;
    pin2_d   = 1'b1;
    pin_a1_d = 1'b1;
    pin3_d   = 1'b1;
    if (width_d == WIDTH_8) begin
      pin0_d   = addr_d[0];
      pin1_d   = !(strobe_d && wr_d);
      pin_a1_d = addr_d[1];
    end else if (bat_d == BAT_WRITE) begin
      // Lane selects are not used here and stay high
      pin0_d = 1'b1;
      pin1_d = !(strobe_d && wr_d && be_d[0]);
      pin2_d = !(strobe_d && wr_d && be_d[1]);
      if (width_d == WIDTH_32) begin
        pin_a1_d = !(strobe_d && wr_d && be_d[2]);
        pin3_d   = !(strobe_d && wr_d && be_d[3]);
      end else begin
        pin_a1_d = addr_d[1];
      end
    end else begin
      // Selects follow the address timing, not the strobe
      pin0_d = !(active_d && be_d[0]);
      pin1_d = !(strobe_d && wr_d);
      pin2_d = !(active_d && be_d[1]);
      if (width_d == WIDTH_32) begin
        pin_a1_d = !(active_d && be_d[2]);
        pin3_d   = !(active_d && be_d[3]);
      end else begin
        pin_a1_d = addr_d[1];
      end
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_q    <= ST_IDLE;
      cnt_q      <= TIM_ZERO;
      cs_q       <= '0;
      addr_q     <= '0;
      wr_q       <= 1'b0;
      be_q       <= LANES_NONE;
      width_q    <= WIDTH_8;
      bat_q      <= BAT_SEL;
      page_vld_q <= 1'b0;
      page_q     <= '0;
      pulse_q    <= TIM_ONE;
      hold_q     <= TIM_ZERO;
      ready_q    <= 1'b1;
      done_q     <= 1'b0;
      rdata_q    <= '0;
      wdata_q    <= '0;
      o_chip_select_n_lines    <= CS_IDLE;
      o_read_strobe_n          <= 1'b1;
      o_pin0_a0_lane0_select_n <= 1'b1;
      o_pin1_write_enable_n    <= 1'b1;
      o_pin2_lane1_n           <= 1'b1;
      o_pin_a1_lane2_n         <= 1'b1;
      o_pin3_lane3_n           <= 1'b1;
      o_data_oe_n              <= 1'b1;
      wait_meta_q              <= 1'b1;
      wait_sync_q              <= 1'b1;
      din_meta_q               <= '0;
      din_sync_q               <= '0;
    end else if (i_clk_en) begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      cs_q       <= cs_d;
      addr_q     <= addr_d;
      wr_q       <= wr_d;
      be_q       <= be_d;
      width_q    <= width_d;
      bat_q      <= bat_d;
      page_vld_q <= page_vld_d;
      page_q     <= page_d;
      pulse_q    <= pulse_d;
      hold_q     <= hold_d;
      ready_q    <= ready_d;
      done_q     <= done_d;
      rdata_q    <= rdata_d;
      wdata_q    <= wdata_d;
      o_chip_select_n_lines    <= cs_n_d;
      o_read_strobe_n          <= rd_n_d;
      o_pin0_a0_lane0_select_n <= pin0_d;
      o_pin1_write_enable_n    <= pin1_d;
      o_pin2_lane1_n           <= pin2_d;
      o_pin_a1_lane2_n         <= pin_a1_d;
      o_pin3_lane3_n           <= pin3_d;
      o_data_oe_n              <= oe_n_d;
      wait_meta_q              <= i_ext_wait_request_n;
      wait_sync_q              <= wait_meta_q;
      din_meta_q               <= i_data_in;
      din_sync_q               <= din_meta_q;
    end
  end
  assign o_req_ready = ready_q;
  assign o_done      = done_q;
  assign o_rdata     = rdata_q;
  assign o_addr_hi   = addr_q[ADDR_W-1:2];
  assign o_data_out  = wdata_q;

endmodule

// ---- tb/lane_map_sva.sv ----
`timescale 1ns/10ps
module lane_map_sva
  import lane_map_pkg::*;
(
  input wire logic                  i_sys_clk,
  input wire logic                  i_rst,
  input wire logic [2*CS_COUNT-1:0] i_bus_width_field,
  input wire logic [CS_COUNT-1:0]   i_byte_access_type_field,
  input wire logic                  i_boot_mode,
  input wire logic                  i_ext_wait_request_n,
  input wire logic                  o_req_ready,
  input wire logic                  o_done,
  input wire logic [CS_COUNT-1:0]   o_chip_select_n_lines,
  input wire logic                  o_read_strobe_n,
  input wire logic                  o_pin0_a0_lane0_select_n,
  input wire logic                  o_pin1_write_enable_n,
  input wire logic                  o_pin2_lane1_n,
  input wire logic                  o_pin_a1_lane2_n,
  input wire logic                  o_pin3_lane3_n,
  input wire logic                  o_data_oe_n
);
  logic [1:0] act_w;
  logic       act_b;
  logic       act_on;

  // Config of the select now low; boot overrides select 0 only
  always_comb begin
    act_w  = WIDTH_8;
    act_b  = BAT_SEL;
    act_on = 1'h0;
    for (int k = 0; k < CS_COUNT; k++) begin
      if (!o_chip_select_n_lines[k]) begin
        act_on = 1'h1;
        act_w  = i_bus_width_field[2*k+:2];
        act_b  = i_byte_access_type_field[k] & !(i_boot_mode && k == 0);
      end
    end
  end

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  chk_cs_onehot: assert property ($onehot0(~o_chip_select_n_lines))
    else $error("several chip selects low");
  chk_rd_in_cs: assert property (!o_read_strobe_n |-> act_on)
    else $error("read strobe without chip select");
  chk_rd_no_we: assert property (!o_read_strobe_n |-> o_pin1_write_enable_n)
    else $error("write strobe during read");
  chk_oe_no_rd: assert property (!o_data_oe_n |-> o_read_strobe_n)
    else $error("data driven during read");
  chk_ready_done: assert property ($rose(o_req_ready) |-> o_done)
    else $error("ready rose without done");
  chk_wait_hold: assert property (
    (!i_ext_wait_request_n [*3] ##0 !o_read_strobe_n) |=> !o_read_strobe_n)
    else $error("read ended while wait held");
  chk_unused_8b: assert property (
    act_on && act_w == WIDTH_8 |-> o_pin2_lane1_n && o_pin3_lane3_n)
    else $error("lane pin active on 8-bit device");
  chk_bw_no_sel: assert property (
    act_on && act_b == BAT_WRITE && act_w != WIDTH_8
    |-> o_pin0_a0_lane0_select_n)
    else $error("lane 0 select in byte write mode");
  chk_no_lane3: assert property (
    act_on && act_w == WIDTH_16 |-> o_pin3_lane3_n)
    else $error("lane 3 active on 16-bit device");
endmodule

// ---- tb/ext_mem_model.sv ----
`timescale 1ns/10ps
module ext_mem_model
  import lane_map_pkg::*;
(
  input  wire logic                i_clk,
  input  wire logic [CS_COUNT-1:0] i_cs_n,
  input  wire logic                i_rd_n,
  input  wire logic [ADDR_W-1:2]   i_addr,
  input  wire logic [7:0]          i_stall,
  output logic [DATA_W-1:0]        o_data,
  output logic                     o_wait_n
);
  logic [7:0]        n;
  logic [DATA_W-1:0] last;
  logic              drv;

  initial begin
    n    = 8'h0;
    last = 32'h0;
  end
  assign drv = !i_rd_n && i_cs_n != CS_IDLE;
  // Released bus shows the inverse of the last word, never a stale copy
  assign o_data = drv ? {8'hA5, i_addr} : ~last;
  assign o_wait_n = !(drv && n < i_stall);
  always @(posedge i_clk) begin
    if (drv) begin
      last <= o_data;
      n    <= (n < i_stall) ? n + 8'h1 : n;
    end else begin
      n <= 8'h0;
    end
  end
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  import lane_map_pkg::*;
  logic clk, rst, en, valid, wr, slow, boot, we_n, oe_n, p1;
  logic [28:0] addr;
  logic [1:0]  sz;
  logic [31:0] wd, su, pu, ho, din, rdat, dout;
  logic [15:0] bw;
  logic [7:0]  byte_access_type_field, pme, stall, cs_n, cs_seen;
  logic [4:0]  seen;
  logic        oe_seen, rdy, done, rd_n, p0, p2, pa1, p3;
  logic [25:2] ahi;
  int n_errors, num_checks;

  static_memory_lane_mapping static_memory_lane_mapping_i (
    .i_sys_clk(clk), .i_rst(rst), .i_clk_en(en), .i_req_valid(valid),
    .i_req_write(wr), .i_req_addr(addr), .i_req_size(sz), .i_req_wdata(wd),
    .i_bus_width_field(bw), .i_byte_access_type_field(byte_access_type_field),
    .i_page_mode_en(pme), .i_setup_cycles(su), .i_pulse_cycles(pu),
    .i_hold_cycles(ho), .i_slow_clock_mode(slow), .i_boot_mode(boot),
    .i_ext_wait_request_n(we_n), .i_data_in(din), .o_req_ready(rdy),
    .o_done(done), .o_rdata(rdat), .o_chip_select_n_lines(cs_n),
    .o_addr_hi(ahi), .o_read_strobe_n(rd_n), .o_pin0_a0_lane0_select_n(p0),
    .o_pin1_write_enable_n(p1), .o_pin2_lane1_n(p2), .o_pin_a1_lane2_n(pa1),
    .o_pin3_lane3_n(p3), .o_data_out(dout), .o_data_oe_n(oe_n));
  ext_mem_model ext_mem_model_i (.i_clk(clk), .i_cs_n(cs_n), .i_rd_n(rd_n),
    .i_addr(ahi), .i_stall(stall), .o_data(din), .o_wait_n(we_n));

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------
  task automatic chk(input logic c, input string m);
    num_checks++;
    if (c !== 1'h1) begin
      n_errors++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Lanes seen low as {pin0, pin1, pin2, pin_a1, pin3}
  function automatic logic [4:0] exp_pins(logic [1:0] w, logic b, logic r,
                                          logic [1:0] z, logic [1:0] a);
    logic [3:0] ln;
    logic       a1;
    if (w == WIDTH_8) return {!a[0], r, 1'h0, !a[1], 1'h0};
    if (w == WIDTH_16) ln = (z == SIZE_BYTE) ? (4'h1 << a[0]) : 4'h3;
    else if (z == SIZE_BYTE) ln = 4'h1 << a;
    else if (z == SIZE_HALF) ln = a[1] ? 4'hC : 4'h3;
    else ln = 4'hF;
    a1 = (w == WIDTH_16) ? !a[1] : ((b == BAT_WRITE) ? r & ln[2] : ln[2]);
    if (b == BAT_WRITE) return {1'h0, r & ln[0], r & ln[1], a1, r & ln[3]};
    return {ln[0], r, ln[1], a1, ln[3]};
  endfunction

  task automatic acc(input logic [2:0] s, input logic w, input logic [25:0] a,
                     input logic [1:0] z, output int t);
    @(negedge clk);
    valid = 1'h1;
    wr = w;
    addr = {s, a};
    sz = z;
    wd = {a[15:0], ~a[15:0]};
    seen = 5'h0;
    cs_seen = 8'h0;
    oe_seen = 1'h0;
    t = 0;
    @(negedge clk);
    valid = 1'h0;
    while (done !== 1'h1 && t < 100) begin
      seen = seen | ~{p0, p1, p2, pa1, p3};
      cs_seen = cs_seen | ~cs_n;
      oe_seen = oe_seen | ~oe_n;
      t++;
      @(negedge clk);
    end
    chk(t < 100, "access never finished");
  endtask

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_map();
    int t;
    logic [2:0] s;
    logic [25:0] a;
    logic [1:0] w, z;
    logic b, r;
    for (int i = 0; i < 144; i++) begin
      w = 2'(i % 3);
      b = 1'((i / 3) % 2);
      r = 1'((i / 6) % 2);
      z = 2'((i / 12) % 3);
      s = 3'(i % 8);
      a = {24'h5A5A5A ^ 24'(i * 7), 2'(i / 36)};
      bw[2*s+:2] = w;
      byte_access_type_field[s] = b;
      acc(s, r, a, z, t);
      chk(seen === exp_pins(w, b, r, z, a[1:0]), "lane pins");
      chk(cs_seen === (8'h1 << s), "chip select");
      chk(ahi === a[25:2], "address bus");
      chk(oe_seen === r, "data drive");
      if (w == WIDTH_32 && z == 2'h2 && r)
        chk(dout === wd, "write data");
      if (w == WIDTH_32 && z == 2'h2 && !r)
        chk(rdat === {8'hA5, a[25:2]}, "read data");
    end
  endtask

  task automatic t_timing();
    int t0, t1, t2;
    acc(3'h1, 1'h0, 26'h100, 2'h2, t0);
    su[12+:4] = 4'h2;
    pu[12+:4] = 4'h4;
    ho[12+:4] = 4'h2;
    acc(3'h3, 1'h0, 26'h100, 2'h2, t1);
    chk(t1 == t0 + 3, "per-select timing");
    slow = 1'h1;
    acc(3'h3, 1'h0, 26'h100, 2'h2, t2);
    chk(t2 == t0, "slow waveform");
    slow = 1'h0;
    su[12+:4] = 4'h0;
    ho[12+:4] = 4'h0;
    acc(3'h3, 1'h0, 26'h100, 2'h2, t2);
    chk(t2 == t0 - 1, "null setup and hold");
  endtask

  task automatic t_wait();
    int t0, t1;
    acc(3'h1, 1'h0, 26'h200, 2'h2, t0);
    stall = 8'h6;
    acc(3'h1, 1'h0, 26'h200, 2'h2, t1);
    stall = 8'h0;
    chk(t1 >= t0 + 4 && t1 <= t0 + 8, "wait stretch");
  endtask

  task automatic t_page();
    int t0, t1;
    pme[2] = 1'h1;
    acc(3'h1, 1'h0, 26'h40, 2'h2, t0);
    acc(3'h2, 1'h0, 26'h40, 2'h2, t0);
    acc(3'h2, 1'h0, 26'h44, 2'h2, t1);
    chk(t1 == t0 - 1, "page hit");
    pme[2] = 1'h0;
  endtask

  task automatic t_boot();
    int t;
    boot = 1'h1;
    bw[1:0] = WIDTH_16;
    byte_access_type_field[0] = BAT_WRITE;
    acc(3'h0, 1'h1, 26'h1, SIZE_BYTE, t);
    chk(seen === exp_pins(WIDTH_16, BAT_SEL, 1'h1, SIZE_BYTE, 2'h1),
        "boot access type");
    boot = 1'h0;
  endtask

  // Software picks card space and register set through address bits
  task automatic t_card();
    int t;
    acc(3'h4, 1'h0, 26'hC00000, 2'h2, t);
    chk(ahi[23:21] === 3'h6, "card space bits");
    acc(3'h5, 1'h1, 26'h200000, 2'h2, t);
    chk(ahi[23:21] === 3'h1, "ide register set");
  endtask

  // Enable low for four edges must stretch the access by four cycles
  task automatic t_freeze();
    int t0, t1;
    acc(3'h1, 1'h0, 26'h300, 2'h2, t0);
    fork
      acc(3'h1, 1'h0, 26'h300, 2'h2, t1);
      begin
        repeat (3) @(negedge clk);
        en = 1'h0;
        repeat (4) @(negedge clk);
        en = 1'h1;
      end
    join
    chk(t1 == t0 + 4, "clock enable freeze");
    chk(rdat === {8'hA5, 24'h0000C0}, "frozen read data");
  endtask

  initial begin
    rst = 1'h1;
    en = 1'h1;
    valid = 1'h0;
    wr = 1'h0;
    addr = 29'h0;
    sz = 2'h0;
    wd = 32'h0;
    bw = 16'h0;
    byte_access_type_field = 8'h0;
    pme = 8'h0;
    su = 32'h11111111;
    pu = 32'h33333333;
    ho = 32'h11111111;
    slow = 1'h0;
    boot = 1'h0;
    stall = 8'h0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'h0;
    t_map();
    t_timing();
    t_wait();
    t_page();
    t_boot();
    t_card();
    t_freeze();
    print_verdict();
  end

  // Whole run is near 1150 cycles; this cuts a hang well beyond that
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
endmodule

bind static_memory_lane_mapping lane_map_sva lane_map_sva_i (
  .i_sys_clk, .i_rst, .i_bus_width_field, .i_byte_access_type_field,
  .i_boot_mode, .i_ext_wait_request_n, .o_req_ready, .o_done,
  .o_chip_select_n_lines, .o_read_strobe_n, .o_pin0_a0_lane0_select_n,
  .o_pin1_write_enable_n, .o_pin2_lane1_n, .o_pin_a1_lane2_n,
  .o_pin3_lane3_n, .o_data_oe_n);
